/* File: shared/frame_pkg.sv */
package frame_pkg;

  // clock and tick timing: every tick length is a power-of-two multiple of the base
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned TICK_BASE_NS     = 1360000;
  localparam int unsigned TICK_BASE_CYCLES = TICK_BASE_NS / CLK_PERIOD_NS;
  localparam int          TICK_W           = 24;

  // tick multipliers as shift counts (1.36 ms units)
  localparam logic [2:0] SH_1_36  = 3'h0;
  localparam logic [2:0] SH_5_44  = 3'h2;
  localparam logic [2:0] SH_21_76 = 3'h4;
  localparam logic [2:0] SH_43_52 = 3'h5;
  localparam logic [2:0] SH_87_04 = 3'h6;

  // frame byte field positions
  localparam int TYPE_BIT  = 7;
  localparam int ATT_LSB   = 5;
  localparam int TICK_LSB  = 3;
  localparam int IDXL_LSB  = 0;
  localparam int RPT_LSB   = 3;
  localparam int TPRES_BIT = 2;
  localparam int TMSB_BIT  = 1;
  localparam int IDXH_BIT  = 0;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN = 8'h08;
  localparam logic [7:0] OFS_CLEAR  = 8'h0c;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_FRAME  = 8'h14;

  // control bits
  localparam int         CTRL_FAST_BIT   = 0;
  localparam int         CTRL_FOLLOW_BIT = 1;
  localparam logic [1:0] CTRL_RST        = 2'h0;

  // status / enable / clear layout
  localparam int         ST_FAULT = 0;
  localparam int         ST_FRAME = 1;
  localparam int         ST_DONE  = 2;
  localparam int         ST_TONE  = 3;
  localparam int         ST_W     = 4;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;

  // tone and period
  localparam logic [8:0]  TONE_RST    = 9'h000;
  localparam logic [10:0] TONE_STEP   = 11'h002;
  localparam logic [10:0] TONE_MIN_HZ = 11'h019;
  localparam logic [15:0] PERIOD_RST  = 16'h0000;
  localparam logic [19:0] US_PER_S    = 20'hf4240;

  typedef enum logic [1:0] {
    DEC_IDLE  = 2'b00,
    DEC_HAVE1 = 2'b01,
    DEC_HAVE2 = 2'b10,
    DEC_PLAY  = 2'b11
  } dec_state_e;

  // tick code to shift count, slow and fast tick tables
  function automatic logic [2:0] tick_shift(input logic fast, input logic [1:0] code);
    logic [2:0] sh;
    sh = SH_1_36;
    case ({fast, code})
      3'b000:  sh = SH_5_44;
      3'b001:  sh = SH_21_76;
      3'b010:  sh = SH_43_52;
      3'b011:  sh = SH_87_04;
      3'b100:  sh = SH_1_36;
      3'b101:  sh = SH_5_44;
      3'b110:  sh = SH_21_76;
      3'b111:  sh = SH_43_52;
      default: sh = SH_1_36;
    endcase
    return sh;
  endfunction

endpackage

/* File: hdl/period_divider.sv */
`timescale 1ns/1ns
// serial restoring divide of one second in microseconds by the tone in hz;
// one quotient bit per cycle keeps the area small, result in 20 cycles
module period_divider
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [10:0] divisor_i,
  output logic             done_o,
  output logic [15:0]      period_o
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [4:0]  cnt;
    logic [11:0] rem;
    logic [19:0] quo;
    logic [10:0] dvsr;
  } div_s;

  div_s        div_q;
  div_s        div_d;
  logic [11:0] trial;

  // one quotient bit per cycle, msb first
  always_comb
  begin
    div_d      = div_q;
    div_d.done = 1'b0;
    trial      = {div_q.rem[10:0], frame_pkg::US_PER_S[div_q.cnt]};
    // a new start restarts a busy divide, so the period always follows the latest tone
    if (start_i)
    begin
      div_d.busy = 1'b1;
      div_d.cnt  = 5'h13;
      div_d.rem  = 12'h000;
      div_d.quo  = 20'h00000;
      div_d.dvsr = divisor_i;
    end
    else if (div_q.busy)
    begin
      if (trial >= {1'b0, div_q.dvsr})
      begin
        div_d.rem            = trial - {1'b0, div_q.dvsr};
        div_d.quo[div_q.cnt] = 1'b1;
      end
      else
      begin
        div_d.rem = trial;
      end
      if (div_q.cnt == 5'h00)
      begin
        div_d.busy = 1'b0;
        div_d.done = 1'b1;
      end
      else
      begin
        div_d.cnt = div_q.cnt - 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_d;
    end
  end

  assign done_o   = div_q.done;
  assign period_o = div_q.quo[15:0]; // divisor never below 25, so it fits
endmodule

/* File: hdl/haptic_frame_decoder.sv */
`timescale 1ns/1ns
module haptic_frame_decoder
#(
  parameter int unsigned TICK_UNIT_CYCLES = frame_pkg::TICK_BASE_CYCLES
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  // frame byte fetcher
  input  wire logic        byte_valid_i,
  input  wire logic [7:0]  byte_data_i,
  input  wire logic        byte_last_i,
  output logic             byte_ready_o,
  // playback engine
  input  wire logic        pass_done_i,
  output logic             frame_valid_o,
  output logic [1:0]       atten_o,
  output logic [23:0]      tick_cycles_o,
  output logic [3:0]       piece_index_o,
  output logic [3:0]       piece_repeat_count_o,
  output logic             restart_from_first_o,
  output logic [8:0]       drive_tone_code_o,
  output logic [10:0]      drive_tone_hz_o,
  output logic             tone_override_o
);

  typedef struct packed {
    frame_pkg::dec_state_e st;
    logic [1:0]            ctrl;
    logic [3:0]            status;
    logic [3:0]            irq_en;
    logic [15:0]           period;
    logic [31:0]           rdata;
    logic                  ack;
    logic [1:0]            atten;
    logic [1:0]            tick_code;
    logic [23:0]           tick_cyc;
    logic [3:0]            index;
    logic [3:0]            repeat_n;
    logic [3:0]            pass_cnt;
    logic                  tone_msb;
    logic [8:0]            tone;
    logic [10:0]           tone_hz;
    logic                  tone_set;
    logic                  div_start;
  } frame_state_s;

  frame_state_s s_q;
  frame_state_s s_d;
  logic         commit;
  logic [3:0]   ev;
  logic [3:0]   clr;
  logic [10:0]  hz_raw;
  logic         div_done;
  logic [15:0]  div_period;
  logic         bus_req;

  // sized copies so the adder and the tick shift keep their widths
  localparam logic [10:0] TONE_STEP_W = frame_pkg::TONE_STEP;
  localparam logic [23:0] TICK_UNIT_W = TICK_UNIT_CYCLES[23:0];

  period_divider u_div
  (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (s_q.div_start),
    .divisor_i (s_q.tone_hz),
    .done_o    (div_done),
    .period_o  (div_period)
  );

  assign bus_req = wb_cyc_i && wb_stb_i;

  // frame assembly, playback tracking and register access
  always_comb
  begin
    s_d          = s_q;
    s_d.div_start = 1'b0;
    commit       = 1'b0;
    ev           = 4'h0;
    clr          = 4'h0;
    byte_ready_o = 1'b0;
    hz_raw       = {1'b0, byte_data_i, 1'b0} + TONE_STEP_W;
    case (s_q.st)
      frame_pkg::DEC_IDLE:
      begin
        byte_ready_o = 1'b1;
        if (byte_valid_i)
        begin
          if (byte_data_i[frame_pkg::TYPE_BIT])
          begin
            ev[frame_pkg::ST_FAULT] = 1'b1; // byte is dropped
          end
          else
          begin
            s_d.atten     = byte_data_i[frame_pkg::ATT_LSB +: 2];
            s_d.tick_code = byte_data_i[frame_pkg::TICK_LSB +: 2];
            s_d.index     = {1'b0, byte_data_i[frame_pkg::IDXL_LSB +: 3]};
            s_d.repeat_n  = 4'h0; // one pass unless byte two says more
            if (byte_last_i)
            begin
              commit = 1'b1;
            end
            else
            begin
              s_d.st = frame_pkg::DEC_HAVE1;
            end
          end
        end
      end
      frame_pkg::DEC_HAVE1:
      begin
        if (byte_valid_i)
        begin
          if (byte_data_i[frame_pkg::TYPE_BIT])
          begin
            byte_ready_o    = 1'b1;
            s_d.repeat_n    = byte_data_i[frame_pkg::RPT_LSB +: 4];
            s_d.index[3]    = byte_data_i[frame_pkg::IDXH_BIT];
            s_d.tone_msb    = byte_data_i[frame_pkg::TMSB_BIT];
            if (byte_data_i[frame_pkg::TPRES_BIT] && !byte_last_i)
            begin
              s_d.st = frame_pkg::DEC_HAVE2;
            end
            else
            begin
              commit = 1'b1;
            end
          end
          else
          begin
            // byte left waiting: it opens the next frame once this one ends
            commit = 1'b1;
          end
        end
      end
      frame_pkg::DEC_HAVE2:
      begin
        byte_ready_o = 1'b1;
        if (byte_valid_i)
        begin
          s_d.tone      = {s_q.tone_msb, byte_data_i};
          hz_raw        = {1'b0, s_q.tone_msb, byte_data_i, 1'b0} + TONE_STEP_W;
          s_d.tone_hz   = (hz_raw < frame_pkg::TONE_MIN_HZ) ? frame_pkg::TONE_MIN_HZ
                                                             : hz_raw;
          s_d.tone_set  = 1'b1; // held from here until reset
          s_d.div_start = 1'b1;
          ev[frame_pkg::ST_TONE] = 1'b1;
          commit        = 1'b1;
        end
      end
      frame_pkg::DEC_PLAY:
      begin
        // no bytes taken while playing so every field stays put
        if (pass_done_i)
        begin
          if (s_q.pass_cnt == s_q.repeat_n)
          begin
            s_d.st = frame_pkg::DEC_IDLE;
            ev[frame_pkg::ST_DONE] = 1'b1;
          end
          else
          begin
            s_d.pass_cnt = s_q.pass_cnt + 4'h1;
          end
        end
      end
      default:
      begin
        s_d.st = frame_pkg::DEC_IDLE;
      end
    endcase

    // frame complete: latch tick length, repeat count and index msb already defaulted, tone kept
    if (commit)
    begin
      s_d.st       = frame_pkg::DEC_PLAY;
      s_d.pass_cnt = 4'h0;
      s_d.tick_cyc = TICK_UNIT_W << frame_pkg::tick_shift(s_q.ctrl[frame_pkg::CTRL_FAST_BIT],
                                                          s_d.tick_code);
      ev[frame_pkg::ST_FRAME] = 1'b1;
    end

    // period read-back follows the divider
    if (div_done)
    begin
      s_d.period = div_period;
    end

    // bus: read data captured on request, ack one cycle later
    s_d.ack = bus_req && !s_q.ack;
    if (bus_req && !s_q.ack)
    begin
      case (wb_adr_i)
        frame_pkg::OFS_CTRL:   s_d.rdata = {30'h0, s_q.ctrl};
        frame_pkg::OFS_STATUS: s_d.rdata = {28'h0, s_q.status};
        frame_pkg::OFS_IRQ_EN: s_d.rdata = {28'h0, s_q.irq_en};
        frame_pkg::OFS_PERIOD: s_d.rdata = {16'h0, s_q.period};
        frame_pkg::OFS_FRAME:  s_d.rdata = {4'h0, s_q.tone_set, s_q.tone, s_q.st,
                                            s_q.atten, s_q.tick_code, s_q.pass_cnt,
                                            s_q.repeat_n, s_q.index};
        default:               s_d.rdata = 32'h0; // unmapped and clear register read 0
      endcase
    end
    // writes land on the edge where the master sees ack
    if (bus_req && s_q.ack && wb_we_i && wb_sel_i[0])
    begin
      case (wb_adr_i)
        frame_pkg::OFS_CTRL:   s_d.ctrl   = wb_dat_i[1:0];
        frame_pkg::OFS_IRQ_EN: s_d.irq_en = wb_dat_i[3:0];
        frame_pkg::OFS_CLEAR:  clr        = wb_dat_i[3:0];
        default:               clr        = 4'h0;
      endcase
    end
    // a fresh event wins over a clear in the same cycle
    s_d.status = (s_q.status & ~clr) | ev;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      s_q          <= '0;
      s_q.st       <= frame_pkg::DEC_IDLE;
      s_q.ctrl     <= frame_pkg::CTRL_RST;
      s_q.status   <= frame_pkg::STATUS_RST;
      s_q.irq_en   <= frame_pkg::IRQ_EN_RST;
      s_q.period   <= frame_pkg::PERIOD_RST;
      s_q.tone     <= frame_pkg::TONE_RST;
      s_q.tone_hz  <= frame_pkg::TONE_MIN_HZ;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign wb_dat_o             = s_q.rdata;
  assign wb_ack_o             = s_q.ack;
  assign irq_o                = |(s_q.status & s_q.irq_en);
  assign frame_valid_o        = (s_q.st == frame_pkg::DEC_PLAY);
  assign atten_o              = s_q.atten;
  assign tick_cycles_o        = s_q.tick_cyc;
  assign piece_index_o        = s_q.index;
  assign piece_repeat_count_o = s_q.repeat_n;
  assign restart_from_first_o = frame_valid_o && (s_q.pass_cnt != 4'h0);
  assign drive_tone_code_o    = s_q.tone;
  assign drive_tone_hz_o      = s_q.tone_hz;
  // the tracking loop would drag a commanded tone away, so it only overrides when off
  assign tone_override_o      = s_q.tone_set && !s_q.ctrl[frame_pkg::CTRL_FOLLOW_BIT];

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_label_fault;
    (s_q.st == frame_pkg::DEC_IDLE) && byte_valid_i && byte_data_i[7]
      |=> s_q.status[frame_pkg::ST_FAULT] && (s_q.st == frame_pkg::DEC_IDLE);
  endproperty
  a_label_fault: assert property (p_label_fault) else $error("label fault not flagged");

  property p_short_frame;
    (s_q.st == frame_pkg::DEC_IDLE) && byte_valid_i && !byte_data_i[7] && byte_last_i
      |=> frame_valid_o && (atten_o == $past(byte_data_i[6:5]))
          && (piece_index_o == {1'b0, $past(byte_data_i[2:0])})
          && (piece_repeat_count_o == 4'h0);
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("one-byte frame decoded wrong");

  property p_tick_slow;
    $rose(frame_valid_o) && !s_q.ctrl[0] && (s_q.tick_code == 2'b11)
      |-> tick_cycles_o == (TICK_UNIT_W << 6);
  endproperty
  a_tick_slow: assert property (p_tick_slow) else $error("slow tick length wrong");

  property p_tick_fast;
    $rose(frame_valid_o) && s_q.ctrl[0] && (s_q.tick_code == 2'b00)
      |-> tick_cycles_o == TICK_UNIT_W;
  endproperty
  a_tick_fast: assert property (p_tick_fast) else $error("fast tick length wrong");

  property p_second_byte;
    (s_q.st == frame_pkg::DEC_HAVE1) && byte_valid_i && byte_data_i[7]
      |-> byte_ready_o ##1 (s_q.repeat_n == $past(byte_data_i[6:3]))
          && (s_q.index[3] == $past(byte_data_i[0]));
  endproperty
  a_second_byte: assert property (p_second_byte) else $error("second byte decoded wrong");

  property p_pass_end;
    frame_valid_o && pass_done_i && (s_q.pass_cnt == s_q.repeat_n)
      |=> !frame_valid_o && s_q.status[frame_pkg::ST_DONE];
  endproperty
  a_pass_end: assert property (p_pass_end) else $error("frame did not end after last pass");

  property p_restart;
    frame_valid_o && pass_done_i && (s_q.pass_cnt != s_q.repeat_n)
      |=> frame_valid_o && restart_from_first_o;
  endproperty
  a_restart: assert property (p_restart) else $error("repeat pass not marked");

  property p_tone_byte;
    (s_q.st == frame_pkg::DEC_HAVE2) && byte_valid_i
      |=> (drive_tone_code_o == {s_q.tone_msb, $past(byte_data_i)}) ##22 (s_q.period != 16'h0);
  endproperty
  a_tone_byte: assert property (p_tone_byte) else $error("tone or period not loaded");

  property p_tone_floor;
    drive_tone_hz_o >= frame_pkg::TONE_MIN_HZ;
  endproperty
  a_tone_floor: assert property (p_tone_floor) else $error("tone below floor");

  property p_tone_held;
    !((s_q.st == frame_pkg::DEC_HAVE2) && byte_valid_i) |=> $stable(drive_tone_code_o);
  endproperty
  a_tone_held: assert property (p_tone_held) else $error("tone changed without command");

  property p_fields_stable;
    frame_valid_o && $past(frame_valid_o)
      |-> $stable(piece_index_o) && $stable(atten_o) && $stable(tick_cycles_o)
          && $stable(piece_repeat_count_o);
  endproperty
  a_fields_stable: assert property (p_fields_stable) else $error("fields moved in play");

  property p_next_frame;
    (s_q.st == frame_pkg::DEC_HAVE1) && byte_valid_i && !byte_data_i[7]
      |-> !byte_ready_o ##1 frame_valid_o;
  endproperty
  a_next_frame: assert property (p_next_frame) else $error("label-0 byte consumed early");

  c_three_byte: cover property ((s_q.st == frame_pkg::DEC_HAVE2) && byte_valid_i);
  c_repeat:     cover property (restart_from_first_o && pass_done_i);
  c_fault_irq:  cover property (s_q.status[frame_pkg::ST_FAULT] && irq_o);
endmodule

/* File: tb/frame_partner.sv */
`timescale 1ns/1ns
// far side of the decoder: frame byte fetcher and playback pass timer
module frame_partner
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       byte_ready_i,
  input  wire logic       frame_valid_i,
  input  wire logic [3:0] lag_i,
  output logic            byte_valid_o,
  output logic [7:0]      byte_data_o,
  output logic            byte_last_o,
  output logic            pass_done_o
);
  logic [8:0] pend_q[$];
  logic [3:0] wait_q;

  // the bench queues {last, data}; bytes leave in the order given
  task automatic push(input logic [7:0] data, input logic last);
    pend_q.push_back({last, data});
  endtask

  // quiet outputs from time zero
  initial
  begin
    byte_valid_o = 1'b0;
    byte_data_o  = 8'h00;
    byte_last_o  = 1'b0;
    pass_done_o  = 1'b0;
    wait_q       = 4'h0;
  end

  // a byte is held until taken; idle data flips every cycle so stale data never looks good
  always @(posedge ref_clk_i)
  begin
    if (byte_valid_o && byte_ready_i && !rst_i)
      void'(pend_q.pop_front());
    byte_valid_o <= !rst_i && pend_q.size() > 0;
    byte_data_o  <= (pend_q.size() > 0) ? pend_q[0][7:0] : ~byte_data_o;
    byte_last_o  <= (pend_q.size() > 0) && pend_q[0][8];
  end

  // each pass lasts lag_i+1 cycles; slow lags keep the frame playing a long while
  always @(posedge ref_clk_i)
  begin
    if (rst_i || !frame_valid_i || wait_q == lag_i)
      wait_q <= 4'h0;
    else
      wait_q <= wait_q + 4'h1;
    pass_done_o <= !rst_i && frame_valid_i && wait_q == lag_i;
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  // short tick unit keeps every timebase between 4 and 256 cycles
  localparam int unsigned TU  = 4;
  // shift per {fast, code}: slow x4/x16/x32/x64, fast x1/x4/x16/x32
  localparam logic [23:0] SHS = {3'h5, 3'h4, 3'h2, 3'h0, 3'h6, 3'h5, 3'h4, 3'h2};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic [3:0]  lag = 4'h1;
  logic [31:0] rdat;
  logic        ack, irq, bvalid, blast, bready, pdone, fvalid, restart, tovr;
  logic [7:0]  bdata;
  wire  [53:0] got_frm;
  logic [53:0] cur_frm;
  logic [53:0] exp_frm[$];
  logic [31:0] exp_rd[$];
  logic [8:0]  tone_now = 9'h000;
  logic        fast_now = 1'b0;
  logic        fv_q = 1'b0;
  logic [4:0]  npass = 5'h00;
  int          n_errors = 0;
  int          checks_done = 0;
  int          seed = 32'hcbda;

  always #5 clk = ~clk;

  frame_partner u_far (.ref_clk_i(clk), .rst_i(rst), .byte_ready_i(bready),
    .frame_valid_i(fvalid), .lag_i(lag), .byte_valid_o(bvalid), .byte_data_o(bdata),
    .byte_last_o(blast), .pass_done_o(pdone));

  haptic_frame_decoder #(.TICK_UNIT_CYCLES(TU)) u_dut (.ref_clk_i(clk), .rst_i(rst),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .byte_valid_i(bvalid),
    .byte_data_i(bdata), .byte_last_i(blast), .byte_ready_o(bready), .pass_done_i(pdone),
    .frame_valid_o(fvalid), .atten_o(got_frm[53:52]), .tick_cycles_o(got_frm[51:28]),
    .piece_index_o(got_frm[27:24]), .piece_repeat_count_o(got_frm[23:20]),
    .restart_from_first_o(restart), .drive_tone_code_o(got_frm[19:11]),
    .drive_tone_hz_o(got_frm[10:0]), .tone_override_o(tovr));

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // hz from tone code, floored so a slow code never stalls the drive
  function automatic logic [10:0] exp_hz(input logic [8:0] c);
    logic [10:0] h;
    h = {1'b0, c, 1'b0} + 11'h002;
    return (h < 11'h019) ? 11'h019 : h;
  endfunction

  // classic single cycle; the answer is awaited, never assumed
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= s;
    cyc <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    cyc <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(a, 1'b0, 32'h0, 4'hf);
  endtask

  // note the decode, then hand the bytes to the fetcher model
  task automatic frame(input logic [1:0] att, input logic [1:0] tk, input logic [3:0] ix,
                       input int nb, input logic [3:0] rp, input logic [8:0] tn, input logic fin);
    logic [2:0] sh;
    sh = SHS[{fast_now, tk} * 3 +: 3];
    if (nb == 3)
      tone_now = tn;
    exp_frm.push_back({att, 24'(TU << sh), nb > 1 ? ix : {1'b0, ix[2:0]}, nb > 1 ? rp : 4'h0,
                       tone_now, exp_hz(tone_now)});
    u_far.push({1'b0, att, tk, ix[2:0]}, fin && nb == 1);
    if (nb > 1)
      u_far.push({1'b1, rp, nb == 3, tn[8], ix[3]}, fin && nb == 2);
    if (nb > 2)
      u_far.push(tn[7:0], fin);
  endtask

  // wait, bounded, until bytes and playback have been quiet a few cycles
  task automatic settle;
    int k;
    int calm;
    k = 0;
    calm = 0;
    while (calm < 4)
    begin
      @(posedge clk);
      k++;
      calm = (fvalid || bvalid) ? 0 : calm + 1;
      if (k > 5000)
      begin
        n_errors++;
        print_verdict();
      end
    end
  endtask

  // results are compared against the oldest note as they appear
  always @(posedge clk)
  begin
    if (ack && !we)
      chk(64'(rdat), 64'(exp_rd.pop_front()), "read data");
    if (fvalid && !fv_q)
    begin
      npass = 5'h00;
      if (exp_frm.size() == 0)
        chk(64'h1, 64'h0, "frame without note");
      else
        cur_frm = exp_frm.pop_front();
      chk(64'(got_frm), 64'(cur_frm), "frame fields");
    end
    if (fvalid && pdone)
    begin
      chk(64'(restart), 64'(npass != 5'h00), "restart");
      chk(64'(got_frm), 64'(cur_frm), "held fields");
      npass = npass + 5'h01;
    end
    if (!fvalid && fv_q)
      chk(64'(npass), 64'(cur_frm[23:20]) + 64'h1, "pass count");
    fv_q <= fvalid;
  end

  initial
  begin
    int i;
    int f;
    logic [35:0] codes;
    codes = {9'h1ff, 9'h00c, 9'h00b, 9'h000};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(frame_pkg::OFS_CTRL, 32'h0);
    rd(frame_pkg::OFS_STATUS, 32'h0);
    rd(frame_pkg::OFS_IRQ_EN, 32'h0);
    rd(frame_pkg::OFS_PERIOD, 32'h0);
    rd(8'h3c, 32'h0);
    chk(64'(got_frm[10:0]), 64'h19, "tone after reset");
    $display("test reset done");
    // every attenuation and tick code, slow and fast tables
    for (f = 0; f < 2; f++)
    begin
      wr(frame_pkg::OFS_CTRL, 32'(f));
      fast_now = f[0];
      for (i = 0; i < 4; i++)
        frame(2'(i), 2'(i), 4'($random(seed)), 1, 4'h0, 9'h0, 1'b1);
      settle();
    end
    wr(frame_pkg::OFS_CTRL, 32'h0);
    fast_now = 1'b0;
    rd(frame_pkg::OFS_STATUS, 32'h6);
    $display("test timebase done");
    // boundary tones, slow passes so the period settles
    lag <= 4'hf;
    for (i = 0; i < 4; i++)
    begin
      frame(2'h0, 2'h0, 4'(i), 3, 4'h1, codes[i * 9 +: 9], 1'b1);
      settle();
      rd(frame_pkg::OFS_PERIOD, 32'(frame_pkg::US_PER_S / exp_hz(tone_now)));
    end
    frame(2'h1, 2'h1, 4'h9, 2, 4'h0, 9'h0, 1'b1);
    settle();
    rd(frame_pkg::OFS_STATUS, 32'he);
    wr(frame_pkg::OFS_CTRL, 32'h2);
    rd(frame_pkg::OFS_CTRL, 32'h2);
    chk(64'(tovr), 64'h0, "override with following");
    wr(frame_pkg::OFS_CTRL, 32'h0);
    rd(frame_pkg::OFS_CTRL, 32'h0);
    chk(64'(tovr), 64'h1, "override kept");
    $display("test tone done");
    // random mix, tones only while following is off
    for (i = 0; i < 8; i++)
    begin
      lag <= 4'h1 | 4'($random(seed));
      frame(2'($random(seed)), 2'($random(seed)), 4'($random(seed)), 1 + {$random(seed)} % 3,
            (i == 0) ? 4'hf : 4'($random(seed)), 9'($random(seed)), 1'b1);
      settle();
    end
    // one-byte frame closed only by the next label-0 byte
    frame(2'h3, 2'h2, 4'h5, 1, 4'h0, 9'h0, 1'b0);
    frame(2'h2, 2'h1, 4'h2, 1, 4'h0, 9'h0, 1'b1);
    settle();
    $display("test mix done");
    // fault event, irq enable, mask, sel guard, clear, read-only status
    wr(frame_pkg::OFS_IRQ_EN, 32'h1);
    u_far.push({1'b1, 7'($random(seed))}, 1'b1);
    settle();
    rd(frame_pkg::OFS_STATUS, 32'hf);
    chk(64'(irq), 64'h1, "irq raised");
    wb(frame_pkg::OFS_IRQ_EN, 1'b1, 32'h0, 4'he);
    rd(frame_pkg::OFS_IRQ_EN, 32'h1);
    wr(frame_pkg::OFS_IRQ_EN, 32'h0);
    rd(frame_pkg::OFS_STATUS, 32'hf);
    chk(64'(irq), 64'h0, "irq masked");
    wr(frame_pkg::OFS_IRQ_EN, 32'h1);
    wr(frame_pkg::OFS_CLEAR, 32'h1);
    wr(frame_pkg::OFS_STATUS, 32'h0);
    rd(frame_pkg::OFS_STATUS, 32'he);
    chk(64'(irq), 64'h0, "irq cleared");
    $display("test fault done");
    print_verdict();
  end
endmodule
